// ---- hdl/oms_pkg.sv ----
`default_nettype none

package oms_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OMS_OFS_TIMEBASE = 8'h24;
  localparam logic [7:0] OMS_OFS_RUN      = 8'h28;
  localparam logic [7:0] OMS_OFS_CYCLE    = 8'h2c;
  localparam logic [7:0] OMS_OFS_EMITTER  = 8'h30;
  localparam logic [7:0] OMS_OFS_INTEG    = 8'h34;
  localparam logic [7:0] OMS_OFS_DPLUS    = 8'h38;
  localparam logic [7:0] OMS_OFS_DMINUS_A = 8'h3c;
  localparam logic [7:0] OMS_OFS_DMINUS_B = 8'h40;
  localparam logic [7:0] OMS_OFS_SAMPLE   = 8'h44;
  localparam logic [7:0] OMS_OFS_MODE     = 8'h48;
  localparam logic [7:0] OMS_OFS_PROGRESS = 8'h80;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int OMS_DIV_LSB      = 8;
  localparam int OMS_COUNT_LSB    = 0;
  localparam int OMS_RUN_BIT      = 0;
  localparam int OMS_WIN_ON_LSB   = 16;
  localparam int OMS_WIN_OFF_LSB  = 0;
  localparam int OMS_ADC_POS_LSB  = 0;
  localparam int OMS_ADC_INC_LSB  = 16;
  localparam int OMS_ADC_FR_LSB   = 24;
  localparam int OMS_ADC_IFR_LSB  = 28;
  localparam int OMS_MODE_MAN_BIT = 0;
  localparam int OMS_MODE_RES_BIT = 1;
  localparam int OMS_MODE_DEM_BIT = 2;
  localparam int OMS_MODE_DEC_LSB = 8;
  localparam int OMS_PRG_POS_LSB  = 0;
  localparam int OMS_PRG_MEAS_LSB = 16;
  localparam int OMS_PRG_SUBS_LSB = 24;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] OMS_RST_TIMEBASE = 32'h0000_0000;
  localparam logic [31:0] OMS_RST_CYCLE    = 32'h0000_0000;
  localparam logic [31:0] OMS_RST_WINDOW   = 32'h0000_0000;
  localparam logic [31:0] OMS_RST_INTEG    = 32'h0001_0000;
  localparam logic [31:0] OMS_RST_SAMPLE   = 32'h0000_0000;
  localparam logic [31:0] OMS_RST_MODE     = 32'h0000_0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int OMS_CLK_NS      = 10;
  localparam int OMS_BASE_TICK_US = 1;
  localparam int OMS_TICK_CYC    = (OMS_BASE_TICK_US * 1000) / OMS_CLK_NS;
  localparam int OMS_FRAC_SHIFT  = 4;

  // ahb-lite encodings
  localparam logic [1:0] OMS_HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] OMS_HTRANS_SEQ    = 2'b11;

endpackage

`default_nettype wire

// ---- hdl/oms_step_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

module oms_step_timer
  import oms_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // control
  input  wire logic        run,
  input  wire logic [15:0] step_div,
  // step enable
  output logic             step_pulse
);

  typedef struct packed {
    logic [6:0]  tick_cnt;
    logic [15:0] div_cnt;
    logic        step;
  } oms_tmr_t;

  oms_tmr_t r;
  oms_tmr_t next_r;

  always_comb
  begin
    next_r      = r;
    next_r.step = 1'b0;
    if (!run)
    begin
      // restart from a clean phase so the first step is a full step
      next_r.tick_cnt = '0;
      next_r.div_cnt  = '0;
    end
    else if (r.tick_cnt == 7'(OMS_TICK_CYC - 1))
    begin
      next_r.tick_cnt = '0;
      if (r.div_cnt >= step_div)
      begin
        next_r.div_cnt = '0;
        next_r.step    = 1'b1;
      end
      else
      begin
        next_r.div_cnt = r.div_cnt + 16'h0001;
      end
    end
    else
    begin
      next_r.tick_cnt = r.tick_cnt + 7'h01;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign step_pulse = r.step;

endmodule

`default_nettype wire

// ---- hdl/oms_sequencer.sv ----
// Behaviour
// - time step is (divider + 1) times the 1 us base tick
// - measurement count sets measurements per sequence; zero runs forever
// - writing one to run bit in sequencer mode starts the sequence
// - writing zero to run bit stops all sequencer activity
// - in manual mode writing one starts a single adc conversion
// - run bit reads one while running or converting, zero after adc done
// - 16-bit period sets measurement cycle length in time steps
// - emitter window between start and stop; drive begins one step after start
// - integrator window between start and stop; reset 1/0 keeps it always on
// - cap mode without demod discharges when off; resistive mode lifts short
// - demod positive phase window from one register's halves
// - demod first negative phase has its own window
// - demod second negative phase has its own window
// - sample position from 16-bit field; position writes while running take effect at the next start, increment writes at the next conversion
// - 4-bit fraction delays sample point in sixteenths of a step
// - after each conversion sample position advances by whole plus fraction
// - read-only progress: subsampling count, measurement count, cycle position
// - decimation ratio lets adc sample slower than the cycle rate
`timescale 1ns/1ps
`default_nettype none

module oms_sequencer
  import oms_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // analog front end controls
  output logic             emitter_drive,
  output logic             integrator_on,
  output logic             cap_discharge,
  output logic             fb_short_release,
  output logic             demod_plus,
  output logic             demod_minus_a,
  output logic             demod_minus_b,
  // adc
  output logic             adc_start,
  input  wire logic        adc_done
);

  typedef struct packed {
    logic [31:0] timebase;
    logic [15:0] cycle_length;
    logic [31:0] emitter_window;
    logic [31:0] integrate_window;
    logic [31:0] demod_plus_window;
    logic [31:0] demod_minus_window_a;
    logic [31:0] demod_minus_window_b;
    logic [31:0] sample_point;
    logic        manual_mode;
    logic        resistive_fb;
    logic        demod_enable;
    logic [7:0]  sampling_decimation_ratio;
    logic        running;
    logic        conv_busy;
    logic [15:0] pos;
    logic [7:0]  meas;
    logic [7:0]  subs;
    logic [19:0] acc;
    logic [23:0] frac_cnt;
    logic        frac_wait;
    logic        emit_pending;
    logic        emit_on;
    logic        itg_on;
    logic        dp_on;
    logic        dma_on;
    logic        dmb_on;
    logic        adc_go;
    logic        done_s1;
    logic        done_s2;
    logic        done_s3;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
  } oms_state_t;

  oms_state_t r;
  oms_state_t next_r;
  logic       step;

  // ------------------------------------------------------------------
  // functions
  // ------------------------------------------------------------------
  function automatic logic win_next(input logic cur, input logic [15:0] p,
                                    input logic [31:0] win);
    if (p == win[OMS_WIN_ON_LSB +: 16])
      win_next = 1'b1;
    else if (p == win[OMS_WIN_OFF_LSB +: 16])
      win_next = 1'b0;
    else
      win_next = cur;
  endfunction

  // clock cycles of a fractional delay: frac/16 of (div+1) base ticks
  function automatic logic [23:0] frac_cycles(input logic [3:0] frac,
                                              input logic [15:0] div);
    logic [31:0] prod;
    prod = 32'(frac) * (32'(div) + 32'd1) * 32'(OMS_TICK_CYC);
    frac_cycles = 24'(prod >> OMS_FRAC_SHIFT);
  endfunction

  // ------------------------------------------------------------------
  // step timer
  // ------------------------------------------------------------------
  oms_step_timer u_timer (
    .mclk       (mclk),
    .arst_n     (arst_n),
    .run        (r.running),
    .step_div   (r.timebase[OMS_DIV_LSB +: 16]),
    .step_pulse (step)
  );

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    logic        addr_ok;
    logic        wr_run;
    logic        run_val;
    logic        fire;
    logic [15:0] npos;
    logic [7:0]  nmeas;
    logic [7:0]  nsubs;
    logic [7:0]  ratio;
    logic [23:0] fdel;
    logic        ended;
    addr_ok = 1'b0;
    wr_run  = 1'b0;
    run_val = 1'b0;
    fire    = 1'b0;
    npos    = r.pos;
    nmeas   = r.meas;
    nsubs   = r.subs;
    ratio   = r.sampling_decimation_ratio;
    fdel    = '0;
    ended   = 1'b0;
    next_r  = r;

    // synchroniser for the adc completion strobe
    next_r.done_s1 = adc_done;
    next_r.done_s2 = r.done_s1;
    next_r.done_s3 = r.done_s2;
    next_r.adc_go  = 1'b0;

    // ------------------------------------------------------------------
    // bus address phase
    // ------------------------------------------------------------------
    addr_ok = hsel && hready && (htrans == OMS_HTRANS_NONSEQ || htrans == OMS_HTRANS_SEQ);
    next_r.wr_pend = addr_ok && hwrite;
    if (addr_ok)
      next_r.wr_addr = haddr[7:0];
    if (addr_ok && !hwrite)
    begin
      case (haddr[7:0])
        OMS_OFS_TIMEBASE: next_r.rdata = {8'h00, r.timebase[23:0]};
        OMS_OFS_RUN:      next_r.rdata = {31'h0, r.running | r.conv_busy};
        OMS_OFS_CYCLE:    next_r.rdata = {16'h0000, r.cycle_length};
        OMS_OFS_EMITTER:  next_r.rdata = r.emitter_window;
        OMS_OFS_INTEG:    next_r.rdata = r.integrate_window;
        OMS_OFS_DPLUS:    next_r.rdata = r.demod_plus_window;
        OMS_OFS_DMINUS_A: next_r.rdata = r.demod_minus_window_a;
        OMS_OFS_DMINUS_B: next_r.rdata = r.demod_minus_window_b;
        OMS_OFS_SAMPLE:   next_r.rdata = r.sample_point;
        OMS_OFS_MODE:     next_r.rdata = {16'h0000, r.sampling_decimation_ratio, 5'h00,
                                          r.demod_enable, r.resistive_fb, r.manual_mode};
        OMS_OFS_PROGRESS: next_r.rdata = {r.subs, r.meas, r.pos};
        default:          next_r.rdata = 32'h0000_0000;
      endcase
    end

    // ------------------------------------------------------------------
    // bus data phase writes
    // ------------------------------------------------------------------
    if (r.wr_pend)
    begin
      case (r.wr_addr)
        OMS_OFS_TIMEBASE: next_r.timebase = {8'h00, hwdata[23:0]};
        OMS_OFS_RUN:
        begin
          wr_run  = 1'b1;
          run_val = hwdata[OMS_RUN_BIT];
        end
        OMS_OFS_CYCLE:    next_r.cycle_length = hwdata[15:0];
        OMS_OFS_EMITTER:  next_r.emitter_window = hwdata;
        OMS_OFS_INTEG:    next_r.integrate_window = hwdata;
        OMS_OFS_DPLUS:    next_r.demod_plus_window = hwdata;
        OMS_OFS_DMINUS_A: next_r.demod_minus_window_a = hwdata;
        OMS_OFS_DMINUS_B: next_r.demod_minus_window_b = hwdata;
        OMS_OFS_SAMPLE:   next_r.sample_point = hwdata;
        OMS_OFS_MODE:
        begin
          next_r.manual_mode               = hwdata[OMS_MODE_MAN_BIT];
          next_r.resistive_fb              = hwdata[OMS_MODE_RES_BIT];
          next_r.demod_enable              = hwdata[OMS_MODE_DEM_BIT];
          next_r.sampling_decimation_ratio = hwdata[OMS_MODE_DEC_LSB +: 8];
        end
        default:
        begin
          next_r.timebase = r.timebase;
        end
      endcase
    end

    // ------------------------------------------------------------------
    // sequencer timing
    // ------------------------------------------------------------------
    if (r.running && step)
    begin
      if (r.pos != 16'h0000 && r.pos >= r.cycle_length)
      begin
        // end of a measurement cycle
        nmeas = r.meas + 8'h01;
        if (r.timebase[OMS_COUNT_LSB +: 8] != 8'h00 &&
            nmeas == r.timebase[OMS_COUNT_LSB +: 8])
          ended = 1'b1;
        npos  = 16'h0001;
        // decimation ratio of zero or one samples every cycle
        nsubs = (ratio <= 8'h01 || r.subs + 8'h01 >= ratio) ? 8'h00 : r.subs + 8'h01;
      end
      else
      begin
        npos = r.pos + 16'h0001;
      end
      next_r.pos  = npos;
      next_r.meas = nmeas;
      next_r.subs = nsubs;
      if (ended)
      begin
        next_r.running = 1'b0;
      end
      else
      begin
        next_r.emit_pending = win_next(r.emit_pending, npos, r.emitter_window);
        // current starts one step after the request so bias can settle, and stops with it
        next_r.emit_on      = r.emit_pending && next_r.emit_pending;
        next_r.itg_on       = win_next(r.itg_on, npos, r.integrate_window);
        next_r.dp_on        = win_next(r.dp_on, npos, r.demod_plus_window);
        next_r.dma_on       = win_next(r.dma_on, npos, r.demod_minus_window_a);
        next_r.dmb_on       = win_next(r.dmb_on, npos, r.demod_minus_window_b);
        if (npos == r.acc[19:4] && nsubs == 8'h00 && !r.frac_wait)
        begin
          fdel = frac_cycles(r.acc[3:0], r.timebase[OMS_DIV_LSB +: 16]);
          if (fdel == 24'h00_0000)
            fire = 1'b1;
          else
          begin
            next_r.frac_wait = 1'b1;
            next_r.frac_cnt  = fdel;
          end
        end
      end
    end

    // fractional delay countdown in clock cycles
    if (r.running && r.frac_wait)
    begin
      if (r.frac_cnt == 24'h00_0001)
      begin
        fire             = 1'b1;
        next_r.frac_wait = 1'b0;
      end
      next_r.frac_cnt = r.frac_cnt - 24'h00_0001;
    end

    if (fire)
    begin
      next_r.adc_go = 1'b1;
      next_r.acc    = r.acc + {r.sample_point[OMS_ADC_INC_LSB +: 8],
                               r.sample_point[OMS_ADC_IFR_LSB +: 4]};
    end

    // ------------------------------------------------------------------
    // run control
    // ------------------------------------------------------------------
    if (r.done_s2 && !r.done_s3)
      next_r.conv_busy = 1'b0;
    if (ended || (wr_run && !run_val))
    begin
      next_r.running      = 1'b0;
      next_r.conv_busy    = 1'b0;
      next_r.frac_wait    = 1'b0;
      next_r.adc_go       = 1'b0;
      next_r.emit_pending = 1'b0;
      next_r.emit_on      = 1'b0;
      next_r.itg_on       = 1'b0;
      next_r.dp_on        = 1'b0;
      next_r.dma_on       = 1'b0;
      next_r.dmb_on       = 1'b0;
    end
    else if (wr_run && run_val)
    begin
      if (r.manual_mode)
      begin
        // a request while busy is ignored, unless that conversion ends now
        if (!r.conv_busy || (r.done_s2 && !r.done_s3))
        begin
          next_r.conv_busy = 1'b1;
          next_r.adc_go    = 1'b1;
        end
      end
      else if (!r.running)
      begin
        // position snapshot taken here; later position writes wait for the next start, increment writes do not
        next_r.running      = 1'b1;
        next_r.pos          = 16'h0000;
        next_r.meas         = 8'h00;
        next_r.subs         = 8'h00;
        next_r.frac_wait    = 1'b0;
        next_r.acc          = {r.sample_point[OMS_ADC_POS_LSB +: 16],
                               r.sample_point[OMS_ADC_FR_LSB +: 4]};
        next_r.emit_pending = 1'b0;
        next_r.emit_on      = 1'b0;
        next_r.itg_on       = 1'b0;
        next_r.dp_on        = 1'b0;
        next_r.dma_on       = 1'b0;
        next_r.dmb_on       = 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r                           <= '0;
      r.timebase                  <= OMS_RST_TIMEBASE;
      r.cycle_length              <= OMS_RST_CYCLE[15:0];
      r.emitter_window            <= OMS_RST_WINDOW;
      r.integrate_window          <= OMS_RST_INTEG;
      r.demod_plus_window         <= OMS_RST_WINDOW;
      r.demod_minus_window_a      <= OMS_RST_WINDOW;
      r.demod_minus_window_b      <= OMS_RST_WINDOW;
      r.sample_point              <= OMS_RST_SAMPLE;
      r.manual_mode               <= OMS_RST_MODE[OMS_MODE_MAN_BIT];
      r.resistive_fb              <= OMS_RST_MODE[OMS_MODE_RES_BIT];
      r.demod_enable              <= OMS_RST_MODE[OMS_MODE_DEM_BIT];
      r.sampling_decimation_ratio <= OMS_RST_MODE[OMS_MODE_DEC_LSB +: 8];
    end
    else
    begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign hrdata           = r.rdata;
  assign emitter_drive    = r.emit_on;
  assign integrator_on    = r.itg_on;
  assign cap_discharge    = !r.resistive_fb && !r.demod_enable && !r.itg_on;
  assign fb_short_release = r.resistive_fb && r.itg_on;
  assign demod_plus       = r.dp_on;
  assign demod_minus_a    = r.dma_on;
  assign demod_minus_b    = r.dmb_on;
  assign adc_start        = r.adc_go;

endmodule

`default_nettype wire

// ---- tb/oms_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

module oms_asserts
  import oms_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        arst_n,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // front end
  input wire logic        emitter_drive,
  input wire logic        integrator_on,
  input wire logic        cap_discharge,
  input wire logic        fb_short_release,
  input wire logic        demod_plus,
  input wire logic        demod_minus_a,
  input wire logic        demod_minus_b,
  input wire logic        adc_start
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  // ------------------------------------------------------------
  // bus phases
  // ------------------------------------------------------------
  sequence rd_at(logic [7:0] a);
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == a;
  endsequence

  sequence stop_wr;
    hsel && hready && htrans[1] && hwrite && haddr[7:0] == OMS_OFS_RUN ##1 !hwdata[0];
  endsequence

  a_zero_wait: assert property (hreadyout)
    else $error("hreadyout low");
  a_okay_resp: assert property (!hresp)
    else $error("error response seen");
  a_unmapped_zero: assert property (rd_at(8'h20) |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_run_reserved: assert property (rd_at(OMS_OFS_RUN) |=> hrdata[31:1] == 31'h0000_0000)
    else $error("run register reserved bits set");
  a_div_top_zero: assert property (rd_at(OMS_OFS_TIMEBASE) |=> hrdata[31:24] == 8'h00)
    else $error("timebase top byte not zero");
  a_stop_clears: assert property (stop_wr |=> !(emitter_drive || integrator_on || demod_plus
    || demod_minus_a || demod_minus_b))
    else $error("window still on after stop");
  a_start_pulse: assert property ($rose(adc_start) |=> !adc_start [*8])
    else $error("conversion start not a single pulse");
  a_short_needs_itg: assert property (fb_short_release |-> integrator_on)
    else $error("short released while integrator off");
  a_discharge_off: assert property (cap_discharge |-> !integrator_on)
    else $error("discharge while integrating");
endmodule

`default_nettype wire

// ---- tb/oms_adc_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module oms_adc_model
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // pacing and handshake
  input  wire logic slow,
  input  wire logic adc_start,
  output logic      adc_done
);
  int cnt;

  // done held four cycles, longer than the two-flop sync needs
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt      <= 0;
      adc_done <= 1'b0;
    end
    else if (adc_start)
      cnt <= slow ? 24 : 7;
    else if (cnt > 0)
    begin
      cnt      <= cnt - 1;
      adc_done <= (cnt <= 4);
    end
    else
      adc_done <= 1'b0;
  end
endmodule

`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %0h got %0h", nm, (e), (g)); end end

module tb_top
  import oms_pkg::*;
;
  logic        mclk = 0, arst_n = 0, hsel = 0, hwrite = 0, slow = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, seed = 32'h1d0a_1991;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic        hready, hreadyout, hresp, adc_done, adc_start, cap_discharge, fb_short_release;
  logic [4:0]  wo;
  logic        mon = 0, m_res = 0, m_dem = 0;
  logic [7:0]  tbl[12] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h40,
                           8'h44, 8'h48, 8'h80};
  int          miscompares = 0, n_tests = 0, nadc = 0, hi[5];

  always #5 mclk = ~mclk;
  assign hready = hreadyout;

  oms_sequencer u_oms_sequencer (.mclk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .emitter_drive(wo[0]),
    .integrator_on(wo[1]), .cap_discharge, .fb_short_release, .demod_plus(wo[2]),
    .demod_minus_a(wo[3]), .demod_minus_b(wo[4]), .adc_start, .adc_done);
  oms_adc_model u_oms_adc_model (.mclk, .arst_n, .slow, .adc_start, .adc_done);

  // ------------------------------------------------------------
  // output monitor
  // ------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (mon)
    begin
      for (int i = 0; i < 5; i++)
        hi[i] += wo[i];
      nadc += adc_start;
      `CHK("short release", m_res & wo[1], fb_short_release)
      `CHK("discharge", !m_res & !m_dem & !wo[1], cap_discharge)
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] msk(input logic [7:0] a);
    case (a)
      8'h24: return 32'h00ff_ffff;
      8'h2c: return 32'h0000_ffff;
      8'h48: return 32'h0000_ff07;
      8'h20, 8'h80: return 32'h0000_0000;
      default: return 32'hffff_ffff;
    endcase
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic hang();
    miscompares++;
    report_and_stop();
  endtask

  task automatic wt();
    int k;
    for (k = 0; k < 16; k++)
    begin
      @(posedge mclk);
      if (hready === 1'b1)
        break;
    end
    if (k == 16)
      hang();
  endtask

  // one single-word transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= OMS_HTRANS_NONSEQ;
    wt();
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    q = hrdata;
  endtask

  task automatic idle();
    logic [31:0] q;
    int k;
    for (k = 0; k < 3000; k++)
    begin
      xfer(1'b0, OMS_OFS_RUN, 32'h0000_0000, q);
      if (q[0] === 1'b0)
        break;
    end
    if (k == 3000)
      hang();
  endtask

  task automatic run_seq(input int dv, input int cn, input int pr, input logic [1:0] md);
    int st[5], sp[5], acc, inc, rt, e;
    logic [31:0] q, sa;
    rt = rnd() % 3;
    m_res = md[0];
    m_dem = md[1];
    xfer(1'b1, OMS_OFS_MODE, {16'h0000, rt[7:0], 5'h00, m_dem, m_res, 1'b0}, q);
    xfer(1'b1, OMS_OFS_TIMEBASE, {8'h00, dv[15:0], cn[7:0]}, q);
    xfer(1'b1, OMS_OFS_CYCLE, {16'h0000, pr[15:0]}, q);
    for (int i = 0; i < 5; i++)
    begin
      st[i] = 1 + rnd() % (pr - 2);
      sp[i] = st[i] + 2 + rnd() % (pr - st[i] - 1);
      xfer(1'b1, OMS_OFS_EMITTER + 8'(4 * i), {st[i][15:0], sp[i][15:0]}, q);
    end
    q = rnd();
    sa = {q[31:24], 7'h00, q[16], 16'(1 + q[15:0] % pr)};
    xfer(1'b1, OMS_OFS_SAMPLE, sa, q);
    acc = int'({sa[15:0], sa[27:24]});
    inc = int'({sa[23:16], sa[31:28]});
    hi = '{default: 0};
    nadc = 0;
    xfer(1'b1, OMS_OFS_RUN, 32'h0000_0001, q);
    mon <= 1'b1;
    xfer(1'b1, OMS_OFS_SAMPLE, 32'h0000_00ff, q);
    idle();
    mon <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      e = (sp[i] - st[i] - (i == 0)) * cn * OMS_TICK_CYC * (dv + 1);
      `CHK("window cycles", e, hi[i])
    end
    e = 0;
    for (int m = 0; m < cn; m++)
      if ((rt < 2 || m % rt == 0) && (acc >> 4) >= 1 && (acc >> 4) <= pr)
      begin
        e++;
        acc += inc;
      end
    `CHK("adc pulses", e, nadc)
    xfer(1'b0, OMS_OFS_PROGRESS, 32'h0000_0000, q);
    // the ending step has already wrapped the position back to one
    `CHK("progress", {8'((rt < 2) ? 0 : cn % rt), cn[7:0], 16'h0001}, q)
    $display("test sequence run done");
  endtask

  initial
  begin
    logic [31:0] q, d;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 12; i++)
    begin
      xfer(1'b0, tbl[i], 32'h0000_0000, q);
      `CHK("reset value", (tbl[i] == 8'h34) ? 32'h0001_0000 : 32'h0000_0000, q)
      if (tbl[i] != OMS_OFS_RUN)
      begin
        d = rnd();
        xfer(1'b1, tbl[i], d, q);
        xfer(1'b0, tbl[i], d, q);
        `CHK("readback", d & msk(tbl[i]), q)
      end
    end
    $display("test registers done");
    for (int r = 0; r < 3; r++)
      run_seq(rnd() % 2, 1 + rnd() % 3, 3 + rnd() % 4, 2'(r));
    // endless sequence, then stop mid-run
    xfer(1'b1, OMS_OFS_TIMEBASE, 32'h0000_0000, q);
    xfer(1'b1, OMS_OFS_RUN, 32'h0000_0001, q);
    repeat (3000) @(posedge mclk);
    xfer(1'b0, OMS_OFS_RUN, 32'h0000_0000, q);
    `CHK("running", 1'b1, q[0])
    xfer(1'b0, OMS_OFS_PROGRESS, 32'h0000_0000, q);
    `CHK("measurements", 1'b1, q[23:16] >= 8'h04)
    xfer(1'b1, OMS_OFS_RUN, 32'h0000_0000, q);
    xfer(1'b0, OMS_OFS_RUN, 32'h0000_0000, q);
    `CHK("stopped", 1'b0, q[0])
    xfer(1'b0, OMS_OFS_PROGRESS, 32'h0000_0000, d);
    repeat (300) @(posedge mclk);
    xfer(1'b0, OMS_OFS_PROGRESS, 32'h0000_0000, q);
    `CHK("counters held", d, q)
    $display("test endless run done");
    // manual conversions, slow then prompt converter
    m_res = 1'b0;
    m_dem = 1'b0;
    xfer(1'b1, OMS_OFS_MODE, 32'h0000_0001, q);
    mon <= 1'b1;
    for (int s = 1; s >= 0; s--)
    begin
      slow <= s[0];
      nadc = 0;
      xfer(1'b1, OMS_OFS_RUN, 32'h0000_0001, q);
      xfer(1'b0, OMS_OFS_RUN, 32'h0000_0000, q);
      if (s == 1)
        `CHK("busy", 1'b1, q[0])
      idle();
      `CHK("conversions", 1, nadc)
    end
    $display("test manual done");
    report_and_stop();
  end
endmodule

bind oms_sequencer oms_asserts u_oms_asserts (.mclk, .arst_n, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hresp, .hrdata, .emitter_drive, .integrator_on,
  .cap_discharge, .fb_short_release, .demod_plus, .demod_minus_a, .demod_minus_b, .adc_start);

`default_nettype wire
